// ==== hdl/scr_pkg.sv ====
// Constants shared by the smart card serial block
package scr_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned CARD_CLK_PERIOD_NS = 125;
	// Longest period that fits, so round down
	localparam int unsigned CARD_DIV_DEF       = CARD_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned DIV_W              = 8;

	// ----------------------------------------------------------------
	// Character frame
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ETU_W      = 9;
	localparam int unsigned BIT_W      = 4;
	localparam logic [ETU_W-1:0] ETU_LAST  = 9'h173;  // 372 basic clocks per bit
	localparam logic [ETU_W-1:0] SAMPLE_PT = 9'h0b9;  // 186th basic clock pulse
	localparam logic [BIT_W-1:0] START_BIT  = 4'h0;
	localparam logic [BIT_W-1:0] PARITY_BIT = 4'h9;   // tenth bit, after nine bit periods
	localparam logic [BIT_W-1:0] ERR_SLOT   = 4'h1;   // relative to parity sample point
	localparam logic [BIT_W-1:0] CHECK_BIT  = 4'h0;
	localparam logic [BIT_W-1:0] POST_LAST  = 4'h2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic TX_EMPTY_RST = 1'b1;
	localparam logic TX_END_RST   = 1'b1;
	localparam logic LINE_IDLE    = 1'b1;

	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'b000,
		ST_RX      = 3'b001,
		ST_RX_POST = 3'b010,
		ST_TX      = 3'b011,
		ST_TX_POST = 3'b100
	} scr_state_t;
endpackage

// ==== hdl/scr_smart_card.sv ====
// Smart card serial engine: card clock, receive, transmit, retransfer
`timescale 1ns/100ps
module scr_smart_card
#(
	parameter int unsigned CARD_DIV = scr_pkg::CARD_DIV_DEF
)
(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      cardModeBit,
	input  wire logic                      fixedClockModeBit,
	input  wire logic                      transmitEnableBit,
	input  wire logic                      receiveEnableBit,
	input  wire logic                      clockFixedLevelBit,
	input  wire logic                      clockOutputEnableBit,
	input  wire logic                      receiveIrqEnable,
	input  wire logic                      transmitIrqEnable,
	input  wire logic [scr_pkg::DATA_W-1:0] txData,
	input  wire logic                      txWrite,
	input  wire logic                      rxDmaRead,
	input  wire logic                      receiveFullClear,
	input  wire logic                      parityErrorClear,
	input  wire logic                      errorSignalClear,
	output logic      [scr_pkg::DATA_W-1:0] rxData,
	output logic                           receiveFullFlag,
	output logic                           parityErrorFlag,
	output logic                           errorSignalFlag,
	output logic                           transmitEndFlag,
	output logic                           transmitEmptyFlag,
	output logic                           receiveFullIrq,
	output logic                           transferErrorIrq,
	output logic                           transmitEmptyIrq,
	output logic                           sckOut,
	output logic                           sckOe,
	input  wire logic                      dataIn,
	output logic                           dataOut,
	output logic                           dataOe
);
	import scr_pkg::*;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CARD_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CARD_DIV / 2);
	// Bit of the outgoing frame at a given bit index
	function automatic logic frameBit(input logic [DATA_W-1:0] d, input logic [BIT_W-1:0] idx);
		if (idx == PARITY_BIT)
			return ^d;
		if (idx == START_BIT)
			return 1'b0;
		return d[3'(idx - 4'h1)];
	endfunction

	// ----------------------------------------------------------------
	// Card clock generation
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] divCnt_q, divCnt_d;
	logic             run_q, run_d;
	logic             sck_q, sck_d;
	logic             sckOe_q, sckOe_d;
	logic             basicTick;
	logic             clkWanted;
	// Run starts at period boundaries; it stops at one only in fixed clock mode, otherwise at once
	always_comb
	begin
		basicTick = (divCnt_q == DIV_LAST);
		clkWanted = cardModeBit & clockOutputEnableBit;
		divCnt_d  = basicTick ? '0 : divCnt_q + 1'b1;
		run_d     = run_q;
		if (!clkWanted && !fixedClockModeBit)
			run_d = 1'b0;
		else if (basicTick)
			run_d = clkWanted;
		sck_d     = run_q ? (divCnt_q >= DIV_HALF) : clockFixedLevelBit;
		sckOe_d   = cardModeBit | fixedClockModeBit | run_q;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			divCnt_q <= '0;
			run_q    <= 1'b0;
			sck_q    <= 1'b0;
			sckOe_q  <= 1'b0;
		end
		else
		begin
			divCnt_q <= divCnt_d;
			run_q    <= run_d;
			sck_q    <= sck_d;
			sckOe_q  <= sckOe_d;
		end
	end

	assign sckOut = sck_q;
	assign sckOe  = sckOe_q;

	// ----------------------------------------------------------------
	// Data line synchroniser
	// ----------------------------------------------------------------
	logic s1_q, s2_q, s3_q, line_q;
	// Level only accepted once two later stages agree
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s1_q   <= LINE_IDLE;
			s2_q   <= LINE_IDLE;
			s3_q   <= LINE_IDLE;
			line_q <= LINE_IDLE;
		end
		else
		begin
			s1_q <= dataIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				line_q <= s3_q;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer and flags
	// ----------------------------------------------------------------
	scr_state_t        state_q, state_d;
	logic [ETU_W-1:0]  etu_q, etu_d;
	logic [BIT_W-1:0]  bit_q, bit_d;
	logic [DATA_W-1:0] rxSh_q, rxSh_d;
	logic [DATA_W-1:0] rxData_q, rxData_d;
	logic [DATA_W-1:0] txData_q, txData_d;
	logic              bad_q, bad_d;
	logic              ers_q, ers_d;
	logic              rxFull_q, rxFull_d;
	logic              perr_q, perr_d;
	logic              transmit_end_flag_q, transmit_end_flag_d;
	logic              tempty_q, tempty_d;
	logic              dOut_q, dOut_d;
	logic              dOe_q, dOe_d;
	logic              rxGood, rxBad, errSeen, txDone, etuEnd;
	always_comb
	begin
		state_d  = state_q;
		etu_d    = etu_q;
		bit_d    = bit_q;
		rxSh_d   = rxSh_q;
		rxData_d = rxData_q;
		txData_d = txWrite ? txData : txData_q;
		bad_d    = bad_q;
		rxGood   = 1'b0;
		rxBad    = 1'b0;
		errSeen  = 1'b0;
		txDone   = 1'b0;
		etuEnd   = basicTick && (etu_q == ETU_LAST);
		// Bit timing: 372 basic clocks per bit
		if (basicTick && state_q != ST_IDLE)
		begin
			etu_d = etuEnd ? '0 : etu_q + 1'b1;
			bit_d = etuEnd ? bit_q + 1'b1 : bit_q;
		end
		unique case (state_q)
			ST_IDLE:
			begin
				etu_d = '0;
				bit_d = START_BIT;
				if (basicTick && cardModeBit && transmitEnableBit && !tempty_q)
					state_d = ST_TX;
				else if (basicTick && cardModeBit && receiveEnableBit && !line_q)
					state_d = ST_RX;
			end
			ST_RX:
			begin
				if (basicTick && etu_q == SAMPLE_PT)
				begin
					if (bit_q == START_BIT && line_q)
						state_d = ST_IDLE;              // false start, glitch
					else if (bit_q == PARITY_BIT)
					begin
						rxData_d = rxSh_q;              // kept even on bad parity
						bad_d    = ^{rxSh_q, line_q};
						rxBad    = bad_d;
						rxGood   = !bad_d;
						state_d  = ST_RX_POST;
						etu_d    = '0;
						bit_d    = START_BIT;
					end
					else if (bit_q != START_BIT)
						rxSh_d = {line_q, rxSh_q[DATA_W-1:1]};
				end
			end
			ST_RX_POST:
			begin
				if (etuEnd && bit_q == POST_LAST)
					state_d = ST_IDLE;
			end
			ST_TX:
			begin
				if (etuEnd && bit_q == PARITY_BIT)
				begin
					state_d = ST_TX_POST;
					bad_d   = 1'b0;
					bit_d   = START_BIT;                // Guard counts from frame end
				end
			end
			ST_TX_POST:
			begin
				if (etuEnd && bit_q == CHECK_BIT && !line_q)
				begin
					errSeen = 1'b1;
					bad_d   = 1'b1;
				end
				if (etuEnd && bit_q == POST_LAST)
				begin
					state_d = bad_q ? ST_TX : ST_IDLE;
					txDone  = !bad_q;
					bit_d   = START_BIT;                // Retransmit restarts at start bit
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
		// Set wins over any clear in the same cycle
		rxFull_d = rxGood | (rxFull_q & ~(rxDmaRead | receiveFullClear));
		perr_d   = rxBad | (perr_q & ~parityErrorClear);
		ers_d    = errSeen | (ers_q & ~errorSignalClear);
		transmit_end_flag_d   = txDone | (transmit_end_flag_q & ~txWrite);
		tempty_d = txDone | (tempty_q & ~txWrite);
		// Line drive: frame bits in transmit, error slot on bad receive
		dOe_d  = (state_q == ST_TX) || (state_q == ST_RX_POST && bad_q && bit_q == ERR_SLOT);
		dOut_d = (state_q == ST_TX) ? frameBit(txData_q, bit_q) : 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q  <= ST_IDLE;
			etu_q    <= '0;
			bit_q    <= '0;
			rxSh_q   <= '0;
			rxData_q <= '0;
			txData_q <= '0;
			bad_q    <= 1'b0;
			ers_q    <= 1'b0;
			rxFull_q <= 1'b0;
			perr_q   <= 1'b0;
			transmit_end_flag_q   <= TX_END_RST;
			tempty_q <= TX_EMPTY_RST;
			dOut_q   <= 1'b0;
			dOe_q    <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			etu_q    <= etu_d;
			bit_q    <= bit_d;
			rxSh_q   <= rxSh_d;
			rxData_q <= rxData_d;
			txData_q <= txData_d;
			bad_q    <= bad_d;
			ers_q    <= ers_d;
			rxFull_q <= rxFull_d;
			perr_q   <= perr_d;
			transmit_end_flag_q   <= transmit_end_flag_d;
			tempty_q <= tempty_d;
			dOut_q   <= dOut_d;
			dOe_q    <= dOe_d;
		end
	end
	// Flags and requests to the CPU and DMA
	assign rxData            = rxData_q;
	assign receiveFullFlag   = rxFull_q;
	assign parityErrorFlag   = perr_q;
	assign errorSignalFlag   = ers_q;
	assign transmitEndFlag   = transmit_end_flag_q;
	assign transmitEmptyFlag = tempty_q;
	assign receiveFullIrq    = receiveIrqEnable & rxFull_q;
	assign transferErrorIrq  = receiveIrqEnable & (perr_q | ers_q);
	assign transmitEmptyIrq  = transmitIrqEnable & transmit_end_flag_q;
	assign dataOut           = dOut_q;
	assign dataOe            = dOe_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_SCK_FIXED: assert property (!run_q |=> sckOut == $past(clockFixedLevelBit))
		else $error("clock not at fixed level while halted");
	AST_SCK_STOP_EDGE: assert property ($fell(run_q) && fixedClockModeBit |-> divCnt_q == '0)
		else $error("clock stopped mid period");
	AST_SCK_START_EDGE: assert property ($rose(run_q) |-> divCnt_q == '0)
		else $error("clock restarted mid period");
	AST_BIT_STEP: assert property (state_q == ST_TX && etuEnd && bit_q < PARITY_BIT
		|=> etu_q == '0 && bit_q == $past(bit_q) + 1'b1)
		else $error("bit period not 372 basic clocks");
	AST_SAMPLE_POINT: assert property ($rose(parityErrorFlag)
		|-> $past(etu_q) == SAMPLE_PT && $past(bit_q) == PARITY_BIT)
		else $error("parity sampled off mid bit");
	AST_PERR_NO_FULL: assert property ($rose(parityErrorFlag) |-> !$rose(receiveFullFlag))
		else $error("bad frame set receive full");
	AST_DMA_READ_CLR: assert property (rxDmaRead && !rxGood |=> !receiveFullFlag)
		else $error("DMA read left receive full set");
	AST_GOOD_HIZ: assert property (state_q == ST_RX_POST && !bad_q |=> !dataOe)
		else $error("line driven after good frame");
	AST_ERR_SIGNAL_LOW: assert property (dataOe && state_q == ST_RX_POST |-> !dataOut && bad_q)
		else $error("error slot not driven low");
	AST_ERS_NO_END: assert property (state_q == ST_TX_POST && bad_q && etuEnd && bit_q == POST_LAST
		|=> state_q == ST_TX && !transmitEndFlag)
		else $error("no retransmit after error signal");
	AST_END_WITH_EMPTY: assert property ($rose(transmitEndFlag) |-> $rose(transmitEmptyFlag))
		else $error("empty flag not set with end flag");
	AST_TX_DONE_CLEAN: assert property (txDone |-> !bad_q)
		else $error("end flag set for errored frame");
	COV_RX_GOOD: cover property (rxGood);
	COV_RX_BAD: cover property (rxBad);
	COV_TX_RETRY: cover property (errSeen);
	COV_TX_DONE: cover property (txDone);
endmodule

// ==== verif/scr_card_model.sv ====
// Behavioural smart card on the shared data line
`timescale 1ns/100ps
module scr_card_model
#(
	parameter int BIT = 744
)
(
	input  wire logic mclk,
	input  wire logic line,
	output logic      cardOe,
	output logic      cardOut
);
	int         nackLeft = 0;
	int         gotCount = 0;
	logic [7:0] got      = 8'h00;
	logic [9:0] bits;
	logic       busy     = 1'b0;

	initial
	begin
		cardOe = 1'b0;
		cardOut = 1'b1;
	end

	task automatic waitCyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// ----------------------------------------------------------------
	// Card to device: one frame, then listen for the error slot
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b, input logic badPar, output logic nack);
		logic [9:0] f;
		f = {badPar ^ (^b), b, 1'b0};
		busy = 1'b1;
		cardOe = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			cardOut = f[i];
			waitCyc(BIT);
		end
		// Released line falls back to the pull-up
		cardOe = 1'b0;
		cardOut = ~cardOut;
		waitCyc(BIT);
		nack = !line;
		waitCyc(2 * BIT);
		busy = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Device to card: mid-bit sampling, optional error signal
	// ----------------------------------------------------------------
	always
	begin
		@(negedge line);
		if (!busy && !cardOe)
		begin
			waitCyc(BIT / 2);
			for (int i = 0; i < 10; i++)
			begin
				bits[i] = line;
				waitCyc(BIT);
			end
			if (nackLeft > 0)
			begin
				nackLeft--;
				cardOe = 1'b1;
				cardOut = 1'b0;
				waitCyc(BIT);
				cardOe = 1'b0;
			end
			else
			begin
				got = bits[8:1];
				gotCount++;
			end
		end
	end
endmodule

// ==== verif/test_scr_smart_card.sv ====
// Self-checking bench for the smart card serial engine
`timescale 1ns/100ps
module test_scr_smart_card;
	import scr_pkg::*;
	// Short divider keeps a bit at 744 cycles
	localparam int DIV = 2;
	localparam int BIT = 372 * DIV;
	logic       mclk = 1'b0;
	logic       rst_n, cardModeBit, fixedClockModeBit, transmitEnableBit, receiveEnableBit;
	logic       clockFixedLevelBit, clockOutputEnableBit, receiveIrqEnable, transmitIrqEnable;
	logic [7:0] txData, rxData;
	logic       txWrite, rxDmaRead, receiveFullClear, parityErrorClear, errorSignalClear;
	logic       receiveFullFlag, parityErrorFlag, errorSignalFlag, transmitEndFlag, transmitEmptyFlag;
	logic       receiveFullIrq, transferErrorIrq, transmitEmptyIrq, sckOut, sckOe;
	logic       dataIn, dataOut, dataOe, cardOe, cardOut, nack, prev;
	int         fails = 0;
	int         numChecks = 0;
	int         n;

	// Pull-up on the data line when nobody drives
	assign dataIn = (dataOe === 1'b1) ? dataOut : (cardOe ? cardOut : 1'b1);

	scr_smart_card #(.CARD_DIV(DIV)) dut (.mclk, .rst_n, .cardModeBit, .fixedClockModeBit,
		.transmitEnableBit, .receiveEnableBit, .clockFixedLevelBit, .clockOutputEnableBit,
		.receiveIrqEnable, .transmitIrqEnable, .txData, .txWrite, .rxDmaRead, .receiveFullClear,
		.parityErrorClear, .errorSignalClear, .rxData, .receiveFullFlag, .parityErrorFlag,
		.errorSignalFlag, .transmitEndFlag, .transmitEmptyFlag, .receiveFullIrq, .transferErrorIrq,
		.transmitEmptyIrq, .sckOut, .sckOe, .dataIn, .dataOut, .dataOe);

	scr_card_model #(.BIT(BIT)) card (.mclk, .line(dataIn), .cardOe, .cardOut);

	initial
	begin
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask

	// Bounded wait of 30 bit periods; the check after it catches a flag that never comes
	task automatic waitHi(ref logic f);
		for (int i = 0; i < 30 * BIT && f !== 1'b1; i++) cyc(1);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		numChecks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Rising card clock edges over 40 cycles
	task automatic countRises();
		n = 0;
		for (int i = 0; i < 40; i++)
		begin
			prev = sckOut;
			cyc(1);
			if (sckOut === 1'b1 && prev === 1'b0) n++;
		end
	endtask

	task automatic stopTest();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog well above the expected 50k cycles
	initial
	begin
		#900000;
		fails++;
		stopTest();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n, cardModeBit, fixedClockModeBit, transmitEnableBit, receiveEnableBit} = '0;
		{clockFixedLevelBit, clockOutputEnableBit, receiveIrqEnable, transmitIrqEnable} = '0;
		{txData, txWrite, rxDmaRead, receiveFullClear, parityErrorClear, errorSignalClear} = '0;
		cyc(10);
		rst_n = 1'b1;
		cyc(1);
		chk({transmitEndFlag, transmitEmptyFlag, receiveFullFlag, parityErrorFlag, errorSignalFlag,
			sckOe, dataOe, sckOut}, 8'hc0);
		chk(rxData, 8'h00);
		$display("test reset done");
		// Power-on order: fixed clock mode, card mode, then clock enable
		fixedClockModeBit = 1'b1;
		cyc(4);
		cardModeBit = 1'b1;
		cyc(4);
		clockOutputEnableBit = 1'b1;
		cyc(8);
		countRises();
		chk(8'(n), 8'(40 / DIV));
		chk(sckOe, 1'b1);
		clockFixedLevelBit = 1'b1;
		cyc(1);
		clockOutputEnableBit = 1'b0;
		cyc(2 * DIV + 2);
		chk(sckOut, 1'b1);
		clockFixedLevelBit = sckOut;
		clockOutputEnableBit = 1'b1;
		cyc(8);
		countRises();
		chk(8'(n), 8'(40 / DIV));
		$display("test card clock done");
		receiveEnableBit = 1'b1;
		receiveIrqEnable = 1'b1;
		card.send(8'ha5, 1'b0, nack);
		chk(nack, 1'b0);
		chk({receiveFullFlag, parityErrorFlag, receiveFullIrq, transferErrorIrq}, 4'b1010);
		chk(rxData, 8'ha5);
		pulse(rxDmaRead);
		chk(receiveFullFlag, 1'b0);
		// Odd phase offset exercises start bit resync
		cyc(3);
		card.send(8'h5a, 1'b1, nack);
		chk(nack, 1'b1);
		chk({receiveFullFlag, parityErrorFlag, receiveFullIrq, transferErrorIrq}, 4'b0101);
		chk(rxData, 8'h5a);
		pulse(parityErrorClear);
		chk(parityErrorFlag, 1'b0);
		$display("test receive done");
		receiveEnableBit = 1'b0;
		transmitEnableBit = 1'b1;
		transmitIrqEnable = 1'b1;
		card.nackLeft = 1;
		txData = 8'h3c;
		pulse(txWrite);
		chk({transmitEndFlag, transmitEmptyFlag}, 2'b00);
		waitHi(errorSignalFlag);
		chk({transmitEndFlag, transmitEmptyFlag, errorSignalFlag, transferErrorIrq}, 4'b0011);
		waitHi(transmitEndFlag);
		chk({transmitEndFlag, transmitEmptyFlag, errorSignalFlag, transmitEmptyIrq}, 4'b1111);
		chk(card.got, 8'h3c);
		chk(8'(card.gotCount), 8'h01);
		pulse(errorSignalClear);
		txData = 8'hc3;
		pulse(txWrite);
		waitHi(transmitEndFlag);
		chk({errorSignalFlag, transmitEndFlag}, 2'b01);
		chk(card.got, 8'hc3);
		$display("test transmit done");
		stopTest();
	end
endmodule
